// ### hdl/eep_pkg.sv
// Shared constants and types for the two-wire serial EEPROM slave
package eep_pkg;
	// Internal programming time and the core clock rate
	localparam int unsigned CLK_MHZ       = 250;
	localparam int unsigned T_WR_MS       = 5;
	localparam int unsigned WR_CYCLES     = T_WR_MS * 1000 * CLK_MHZ;
	// Array density: 8 to 11 address bits (256 to 2048 bytes)
	localparam int unsigned ADDR_BITS_MIN = 8;
	localparam int unsigned ADDR_BITS_MAX = 11;
	localparam int unsigned ADDR_BITS_DEF = 8;
	// Page buffer geometry
	localparam int unsigned PAGE_BYTES    = 16;
	localparam int unsigned PAGE_BITS     = 4;
	// Slave address byte layout
	localparam logic [3:0]  DEV_TYPE      = 4'ha;
	localparam int unsigned BLK_LSB       = 1;
	localparam int unsigned RW_BIT        = 0;
	localparam logic [3:0]  BYTE_BITS     = 4'h8;
	// Synchroniser reset: both bus lines idle high, protect low
	localparam logic [2:0]  SYNC_RST      = 3'h6;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_DEV  = 4'h1,
		S_DACK = 4'h2,
		S_WADR = 4'h3,
		S_AACK = 4'h4,
		S_WDAT = 4'h5,
		S_WACK = 4'h6,
		S_RDAT = 4'h7,
		S_RACK = 4'h8
	} eep_state_e;
endpackage

// ### hdl/eep_ifs.sv
`timescale 1ns/1ps
// Carriers between the slave core, its pin synchroniser and its store

// Synchronised pin levels
interface eep_pin_if;
	logic scl;
	logic sda;
	logic wp;
	modport src (output scl, sda, wp);
	modport dst (input scl, sda, wp);
endinterface

// Byte store ports: one write and one registered read
interface eep_mem_if #(parameter int unsigned AW = 8);
	logic          we;
	logic [AW-1:0] waddr;
	logic [7:0]    wdata;
	logic [AW-1:0] raddr;
	logic [7:0]    rdata;
	modport ctl (output we, waddr, wdata, raddr, input rdata);
	modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

// ### hdl/eep_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for the bus lines and the protect input
module eep_sync
	import eep_pkg::*;
(
	input  wire logic  sys_clk_in,
	input  wire logic  sys_rst_in,
	input  wire logic  scl_in,
	input  wire logic  sda_in,
	input  wire logic  wp_in,
	eep_pin_if.src     pins
);
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
	} eep_sync_s;

	eep_sync_s st;
	eep_sync_s next_st;

	// First stage feeds only the second stage
	always_comb begin
		next_st.s1 = {scl_in, sda_in, wp_in};
		next_st.s2 = st.s1;
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			st <= {SYNC_RST, SYNC_RST};
		end else begin
			st <= next_st;
		end
	end

	assign pins.scl = st.s2[2];
	assign pins.sda = st.s2[1];
	assign pins.wp  = st.s2[0];
endmodule

// ### hdl/eep_store.sv
`timescale 1ns/1ps
// Byte array with one write port and a registered read port
module eep_store
	import eep_pkg::*;
#(
	parameter int unsigned ADDR_BITS = ADDR_BITS_DEF
) (
	input  wire logic  sys_clk_in,
	input  wire logic  sys_rst_in,
	eep_mem_if.mem     mem
);
	localparam int unsigned DEPTH = 1 << ADDR_BITS;

	typedef struct packed {
		logic [DEPTH-1:0][7:0] arr;
		logic [7:0]            rdata;
	} eep_store_s;

	eep_store_s st;
	eep_store_s next_st;

	// Read is taken from the old contents; a same-cycle write shows next cycle
	always_comb begin
		next_st = st;
		next_st.rdata = st.arr[mem.raddr];
		if (mem.we) begin
			next_st.arr[mem.waddr] = mem.wdata;
		end
	end

	// Array content survives reset, as a nonvolatile store must
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			st.rdata <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign mem.rdata = st.rdata;
endmodule

// ### hdl/eep_slave.sv
`timescale 1ns/1ps
// Two-wire serial EEPROM slave: page write, busy polling and reads

// Overview of operation
// - Up to sixteen data bytes form one page
// - Ack each write byte, bump low four bits
// - Write pointer wraps within its page
// - Extra bytes overwrite earlier buffered positions
// - Stop after write commits page over sixteen cycles
// - Bus inputs ignored while programming
// - No address ack while programming runs
// - Ack matching address after programming ends
// - Direction bit one selects a read
// - Counter holds last accessed address plus one
// - Read address alone returns counter byte
// - Counter at top rolls to address zero
// - Repeated Start then read from loaded address
// - Master ack fetches next address byte
// - Read counter spans whole array
// - Read counter wraps past top to zero
// - Upper nibble must match device type
// - Middle bits: chip pins or block select
// - Ack by pulling SDA low, ninth clock
// - Protect input high makes array read-only
module eep_slave
	import eep_pkg::*;
#(
	parameter int unsigned ADDR_BITS   = ADDR_BITS_DEF,
	parameter int unsigned BUSY_CYCLES = WR_CYCLES
) (
	input  wire logic sys_clk_in,
	input  wire logic sys_rst_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output wire logic sda_out,
	output wire logic sda_oe_out,
	input  wire logic wp_in,
	input  wire logic chip_select_pin_0_in,
	input  wire logic chip_select_pin_1_in,
	input  wire logic chip_select_pin_2_in,
	output wire logic busy_out
);
	localparam int unsigned CNT_W = $clog2(BUSY_CYCLES + 1);

	// Refuse densities and busy spans the logic cannot serve
	if (ADDR_BITS < ADDR_BITS_MIN || ADDR_BITS > ADDR_BITS_MAX) begin : g_bad_aw
		$error("ADDR_BITS must lie between 8 and 11");
	end
	if (BUSY_CYCLES < PAGE_BYTES + 1) begin : g_bad_busy
		$error("BUSY_CYCLES must exceed the page commit length");
	end

	typedef struct packed {
		eep_state_e                 fsm;
		logic                       scl_q;
		logic                       sda_q;
		logic [3:0]                 bitn;
		logic [7:0]                 shf;
		logic [2:0]                 blk;
		logic                       rd;
		logic                       mack;
		logic                       drive;
		logic [ADDR_BITS-1:0]       addr;
		logic [PAGE_BYTES-1:0][7:0] pbuf;
		logic [PAGE_BYTES-1:0]      pval;
		logic                       wrote;
		logic                       busy;
		logic                       commit;
		logic [PAGE_BITS-1:0]       cidx;
		logic [CNT_W-1:0]           bcnt;
		logic [2:0]                 cs_s1;
		logic [2:0]                 cs_s2;
	} eep_core_s;

	eep_core_s  st;
	eep_core_s  next_st;
	eep_pin_if  pins ();
	eep_mem_if  #(.AW(ADDR_BITS)) mem ();
	logic [2:0] cs_pins;
	logic       scl_rise;
	logic       scl_fall;
	logic       start;
	logic       stop;
	logic       byte_done;

	eep_sync u_sync (
		.sys_clk_in (sys_clk_in),
		.sys_rst_in (sys_rst_in),
		.scl_in     (scl_in),
		.sda_in     (sda_in),
		.wp_in      (wp_in),
		.pins       (pins.src)
	);

	eep_store #(.ADDR_BITS(ADDR_BITS)) u_store (
		.sys_clk_in (sys_clk_in),
		.sys_rst_in (sys_rst_in),
		.mem        (mem.mem)
	);

	// Middle slave-address bits are either compared with pins or block bits
	function automatic logic dev_ok(input logic [7:0] d, input logic [2:0] p);
		logic ok;
		ok = (d[7:4] == DEV_TYPE);
		for (int i = 0; i < 3; i++) begin
			if (i >= ADDR_BITS - ADDR_BITS_MIN && d[BLK_LSB + i] != p[i]) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

	// Block-select bits sit above the word address on dense arrays
	function automatic logic [ADDR_BITS-1:0] full_addr(
		input logic [2:0] b,
		input logic [7:0] w
	);
		logic [ADDR_BITS_MAX-1:0] f;
		f = {b, w};
		return f[ADDR_BITS-1:0];
	endfunction

	// Straps are pins as well, so only their second flop reaches the compare
	assign cs_pins = st.cs_s2;

	// Bus events seen from the synchronised lines and their last sample
	assign scl_rise  = pins.scl & ~st.scl_q;
	assign scl_fall  = ~pins.scl & st.scl_q;
	assign start     = st.scl_q & pins.scl & st.sda_q & ~pins.sda;
	assign stop      = st.scl_q & pins.scl & ~st.sda_q & pins.sda;
	assign byte_done = scl_fall && st.bitn == BYTE_BITS;

	// Next-state logic; programming blocks every bus event
	always_comb begin
		logic load;
		load = 1'b0;
		next_st = st;
		next_st.scl_q = pins.scl;
		next_st.sda_q = pins.sda;
		next_st.cs_s1 = {chip_select_pin_2_in, chip_select_pin_1_in, chip_select_pin_0_in};
		next_st.cs_s2 = st.cs_s1;

		// Commit the buffered page, one byte a cycle, inside the busy span
		if (st.commit) begin
			next_st.cidx = st.cidx + 1'b1;
			if (st.cidx == PAGE_BITS'(PAGE_BYTES - 1)) begin
				next_st.commit = 1'b0;
				next_st.pval   = '0;
			end
		end

		if (st.busy) begin
			// Bus is not looked at until the timer runs out
			if (st.bcnt == '0) begin
				next_st.busy = 1'b0;
			end else begin
				next_st.bcnt = st.bcnt - 1'b1;
			end
		end else if (start) begin
			// A fresh or repeated Start; polling lands here once idle again
			next_st.fsm   = S_DEV;
			next_st.bitn  = '0;
			next_st.drive = 1'b0;
			next_st.wrote = 1'b0;
			next_st.pval  = '0;
		end else if (stop) begin
			next_st.fsm   = S_IDLE;
			next_st.drive = 1'b0;
			next_st.wrote = 1'b0;
			if (st.wrote) begin
				if (pins.wp) begin
					next_st.pval = '0;
				end else begin
					next_st.busy   = 1'b1;
					next_st.commit = 1'b1;
					next_st.cidx   = '0;
					next_st.bcnt   = CNT_W'(BUSY_CYCLES - 1);
				end
			end
		end else begin
			case (st.fsm)
				S_DEV, S_WADR, S_WDAT: begin
					if (scl_rise) begin
						next_st.shf  = {st.shf[6:0], pins.sda};
						next_st.bitn = st.bitn + 1'b1;
					end else if (byte_done) begin
						next_st.bitn = '0;
						case (st.fsm)
							S_DEV: begin
								if (dev_ok(st.shf, cs_pins)) begin
									next_st.rd    = st.shf[RW_BIT];
									next_st.blk   = st.shf[BLK_LSB +: 3];
									next_st.drive = 1'b1;
									next_st.fsm   = S_DACK;
								end else begin
									next_st.fsm = S_IDLE;
								end
							end
							S_WADR: begin
								// Dummy write: loads the counter, data may never follow
								next_st.addr  = full_addr(st.blk, st.shf);
								next_st.drive = 1'b1;
								next_st.fsm   = S_AACK;
							end
							default: begin
								// Pointer wraps in page, so late bytes replace early ones
								next_st.pbuf[st.addr[PAGE_BITS-1:0]] = st.shf;
								next_st.pval[st.addr[PAGE_BITS-1:0]] = 1'b1;
								next_st.addr[PAGE_BITS-1:0] =
									st.addr[PAGE_BITS-1:0] + 1'b1;
								next_st.wrote = 1'b1;
								next_st.drive = 1'b1;
								next_st.fsm   = S_WACK;
							end
						endcase
					end
				end
				S_DACK: begin
					if (scl_fall) begin
						next_st.drive = 1'b0;
						if (st.rd) begin
							load = 1'b1;
						end else begin
							next_st.fsm = S_WADR;
						end
					end
				end
				S_AACK, S_WACK: begin
					if (scl_fall) begin
						next_st.drive = 1'b0;
						next_st.fsm   = S_WDAT;
					end
				end
				S_RDAT: begin
					// Shift out MSB first, changing only while SCL is low
					if (scl_fall) begin
						if (st.bitn == BYTE_BITS) begin
							next_st.drive = 1'b0;
							next_st.fsm   = S_RACK;
						end else begin
							next_st.drive = ~st.shf[6];
							next_st.shf   = {st.shf[6:0], 1'b0};
							next_st.bitn  = st.bitn + 1'b1;
						end
					end
				end
				S_RACK: begin
					if (scl_rise) begin
						next_st.mack = ~pins.sda;
					end else if (scl_fall) begin
						if (st.mack) begin
							load = 1'b1;
						end else begin
							next_st.fsm = S_IDLE;
						end
					end
				end
				default: begin
					next_st.fsm = S_IDLE;
				end
			endcase
		end

		// Put the byte at the counter on the line and step the counter
		if (load) begin
			next_st.shf   = mem.rdata;
			next_st.drive = ~mem.rdata[7];
			next_st.addr  = st.addr + 1'b1;
			next_st.bitn  = 4'h1;
			next_st.fsm   = S_RDAT;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			st       <= '0;
			st.scl_q <= 1'b1; // Idle bus level, so no false edge follows reset
			st.sda_q <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Store hookup: the read address follows the counter so data is ready early
	assign mem.we    = st.commit & st.pval[st.cidx];
	assign mem.waddr = {st.addr[ADDR_BITS-1:PAGE_BITS], st.cidx};
	assign mem.wdata = st.pbuf[st.cidx];
	assign mem.raddr = st.addr;

	// Open-drain SDA: only ever pulled low
	assign sda_out    = 1'b0;
	assign sda_oe_out = st.drive;
	assign busy_out   = st.busy;

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	chk_busy_silent: assert property (
		st.busy |-> !st.drive && st.fsm == S_IDLE
	) else $error("device active while programming");

	chk_commit_start: assert property (
		(!st.busy && stop && st.wrote && !pins.wp) |=> st.busy && st.commit && st.cidx == '0
	) else $error("stop after write did not start programming");

	chk_wp_block: assert property (
		(!st.busy && stop && st.wrote && pins.wp) |=> !st.busy && st.pval == '0
	) else $error("protected write started programming");

	chk_page_wrap: assert property (
		(!st.busy && !start && !stop && st.fsm == S_WDAT && byte_done)
		|=> st.addr[PAGE_BITS-1:0] == $past(st.addr[PAGE_BITS-1:0]) + 1'b1
		&& st.addr[ADDR_BITS-1:PAGE_BITS] == $past(st.addr[ADDR_BITS-1:PAGE_BITS])
		&& st.drive && st.fsm == S_WACK
	) else $error("write pointer step or ack wrong");

	chk_read_step: assert property (
		(!st.busy && !start && !stop && st.fsm == S_RACK && scl_fall && st.mack)
		|=> st.addr == $past(st.addr) + 1'b1 && st.fsm == S_RDAT
		&& st.drive == !$past(mem.rdata[7])
	) else $error("sequential read did not advance");

	chk_dev_ack: assert property (
		(!st.busy && !start && !stop && st.fsm == S_DEV && byte_done
		&& dev_ok(st.shf, cs_pins)) |=> st.fsm == S_DACK && st.drive
	) else $error("matching address not acknowledged");

	chk_type_match: assert property (
		(!st.busy && !start && !stop && st.fsm == S_DEV && byte_done
		&& st.shf[7:4] != DEV_TYPE) |=> st.fsm == S_IDLE && !st.drive
	) else $error("foreign address answered");

	chk_commit_len: assert property (
		$rose(st.commit) |-> st.commit [*8] ##1 st.commit [*8] ##1 !st.commit && st.busy
	) else $error("page commit length wrong");

	chk_first_byte: assert property (
		(!st.busy && !start && !stop && st.fsm == S_DACK && scl_fall && st.rd)
		|=> st.fsm == S_RDAT && st.shf == $past(mem.rdata) && st.bitn == 4'h1
	) else $error("read did not load counter byte");
endmodule

// ### test/eep_master_model.sv
// Two-wire bus master model that drives the slave under test
`timescale 1ns/1ps
module eep_master_model (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	// Bus idles released: SCL high, SDA left to the pull-up
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	// One quarter of the 80 ns bus period, launched just after a core edge
	task automatic q();
		repeat (5) @(posedge clk_in);
		#1;
	endtask

	// One bit: data set while SCL low, wire sampled mid-way through SCL high
	task automatic bit_x(input logic b, output logic s);
		sda_low_out = !b;
		q();
		scl_out = 1'b1;
		q();
		s = sda_in;
		q();
		scl_out = 1'b0;
		q();
	endtask

	// Start, also as a repeated start from SCL low
	task automatic start();
		sda_low_out = 1'b0;
		q();
		scl_out = 1'b1;
		q();
		sda_low_out = 1'b1;
		q();
		scl_out = 1'b0;
		q();
	endtask

	// Stop leaves SCL standing high until the next frame
	task automatic stop();
		sda_low_out = 1'b1;
		q();
		scl_out = 1'b1;
		q();
		sda_low_out = 1'b0;
		q();
	endtask

	// Byte out MSB first, ninth clock released so the slave can acknowledge
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(d[i], s);
		bit_x(1'b1, s);
		ack = !s;
	endtask

	// Byte in, then acknowledge to continue or leave SDA high to end
	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, s);
			d[i] = s;
		end
		bit_x(!ack, s);
	endtask
endmodule

// ### test/tb_top.sv
// Self-checking bench for the two-wire serial EEPROM slave
`timescale 1ns/1ps
module tb_top;
	import eep_pkg::*;
	// Short busy interval keeps polling visible without a 5 ms run
	localparam int unsigned BUSY = 300;
	logic       clk, rst, wp, scl, m_low, sda_oe, sda_o, busy;
	logic [2:0] cs;
	wire        sda_w;
	logic [7:0] mem [256];
	logic [7:0] ctr;
	int         failures, n_checks;

	// Open-drain wire with pull-up
	assign sda_w = (m_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

	eep_slave #(.ADDR_BITS(8), .BUSY_CYCLES(BUSY)) i_dut (
		.sys_clk_in(clk), .sys_rst_in(rst), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_o), .sda_oe_out(sda_oe), .wp_in(wp),
		.chip_select_pin_0_in(cs[0]), .chip_select_pin_1_in(cs[1]),
		.chip_select_pin_2_in(cs[2]), .busy_out(busy));
	eep_master_model i_mst (.clk_in(clk), .sda_in(sda_w), .scl_out(scl), .sda_low_out(m_low));

	// 250 MHz core clock
	always #2 clk = ~clk;

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	function automatic logic [7:0] dev(input logic rw);
		return {DEV_TYPE, cs, rw};
	endfunction

	// Address byte that must not be answered
	task automatic miss(input logic [7:0] b);
		logic k;
		i_mst.start();
		i_mst.wr_byte(b, k);
		i_mst.stop();
		chk("miss_ack", k, 8'h00);
	endtask

	// Polls straight after Stop; the first poll shows whether programming runs
	task automatic poll(input logic busy_exp);
		logic a;
		int   tries;
		repeat (8) @(posedge clk);
		chk("busy", busy, busy_exp);
		tries = 0;
		do begin
			i_mst.start();
			i_mst.wr_byte(dev(1'b0), a);
			i_mst.stop();
			if (tries == 0) chk("poll_ack", a, !busy_exp);
			tries++;
		end while (!a && tries < 20);
		chk("ready_ack", a, 8'h01);
		chk("busy_end", busy, 8'h00);
		if (!a) test_done();
	endtask

	// Page write of n random bytes; the model wraps inside the page
	task automatic page_write(input logic [7:0] a, input int n);
		logic       k;
		logic [7:0] d;
		i_mst.start();
		i_mst.wr_byte(dev(1'b0), k);
		chk("dev_ack", k, 1);
		i_mst.wr_byte(a, k);
		chk("adr_ack", k, 1);
		ctr = a;
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			i_mst.wr_byte(d, k);
			chk("dat_ack", k, 1);
			if (!wp) mem[ctr] = d;
			ctr[3:0] = ctr[3:0] + 4'h1;
		end
		i_mst.stop();
		poll(!wp);
	endtask

	// Read from the current counter, acknowledging all but the last byte
	task automatic seq_read(input int n);
		logic       k;
		logic [7:0] d;
		i_mst.start();
		i_mst.wr_byte(dev(1'b1), k);
		chk("rd_ack", k, 1);
		for (int i = 0; i < n; i++) begin
			i_mst.rd_byte(i < n - 1, d);
			if (!$isunknown(mem[ctr])) chk("rd_data", d, mem[ctr]);
			ctr++;
		end
		i_mst.stop();
	endtask

	// Dummy write loads the counter, then a repeated Start reads
	task automatic rand_read(input logic [7:0] a, input int n);
		logic k;
		i_mst.start();
		i_mst.wr_byte(dev(1'b0), k);
		i_mst.wr_byte(a, k);
		chk("dummy_ack", k, 1);
		ctr = a;
		seq_read(n);
	endtask

	// Main sequence: corner cases first, then random page traffic
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		wp = 1'b0;
		failures = 0;
		n_checks = 0;
		void'($urandom(32'h5fd8));
		cs = 3'($urandom);
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk("busy_rst", busy, 8'h00);
		chk("oe_rst", sda_oe, 8'h00);
		miss({4'h5, cs, 1'b0});
		miss({DEV_TYPE, ~cs, 1'b0});
		page_write(8'hf4, 16);
		page_write(8'h0c, 20);
		seq_read(3);
		rand_read(8'hfe, 4);
		rand_read(8'hff, 1);
		seq_read(2);
		wp = 1'b1;
		page_write(8'h02, 2);
		wp = 1'b0;
		rand_read(8'h00, 4);
		for (int r = 0; r < 4; r++) begin
			page_write(8'($urandom), 16 + $urandom_range(4));
			rand_read(8'($urandom), 3 + $urandom_range(18));
		end
		test_done();
	end

	// Watchdog against a hung bus
	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		test_done();
	end
endmodule
